// ---- core/adcf_pkg.sv ----
// constants, mode codes and state record of the serial frame controller
// assumes one core clock; the serial link pins arrive asynchronously
package adcf_pkg;

    localparam int unsigned CONV_EDGES  = 16;
    localparam int unsigned CTRL_BITS   = 8;
    localparam int unsigned HOLD_FALL   = 4;
    localparam int unsigned CHAN_MSB    = 5;
    localparam int unsigned CHAN_LSB    = 3;
    localparam int unsigned RES_BITS    = 12;
    localparam int unsigned OUT_BITS    = 16;
    localparam int unsigned FIFO_DEPTH  = 8;

    localparam logic [4:0] CNT_IDLE     = 5'h00;
    localparam logic [4:0] CNT_FIRST    = 5'h01;
    localparam logic [4:0] CNT_HOLD     = 5'h04;
    localparam logic [4:0] CNT_CTRL     = 5'h08;
    localparam logic [4:0] CNT_LAST     = 5'h10;
    localparam logic [2:0] CHAN_RESET   = 3'h0;
    localparam logic [7:0] CTRL_RESET   = 8'h00;
    localparam logic [1:0] SYNC_CS_RST  = 2'h3;
    localparam logic [1:0] SYNC_LO_RST  = 2'h0;
    localparam logic [3:0] LEAD_ZEROS   = 4'h0;

    // gray order along power-down, track, hold
    typedef enum logic [1:0] {
        MODE_DOWN  = 2'h0,
        MODE_TRACK = 2'h1,
        MODE_HOLD  = 2'h3
    } adcf_mode_t;

    typedef struct packed {
        logic [1:0]  csSync;
        logic [1:0]  sclkSync;
        logic [1:0]  dinSync;
        logic        iclkPrev;
        logic [4:0]  fallCnt;
        logic [4:0]  riseCnt;
        logic [7:0]  shiftIn;
        logic [7:0]  ctrlWord;
        logic [2:0]  pendChan;
        logic [2:0]  chan;
        logic [15:0] shiftOut;
        adcf_mode_t  mode;
        logic        doutOe;
        logic        ctrlStrobe;
        logic        sampleStrobe;
        logic        underrun;
    } adcf_state_t;

    typedef struct packed {
        logic        valid;
        logic [11:0] data;
    } adcf_result_t;

endpackage

// ---- core/adcf_frame_ctrl.sv ----
// serial frame, conversion sequencing and result buffer of the converter
// assumes core_clk well above the serial clock; pins are asynchronous

module adcf_fifo #(
    parameter int unsigned WIDTH = adcf_pkg::RES_BITS,
    parameter int unsigned DEPTH = adcf_pkg::FIFO_DEPTH
) (
    input  wire logic             core_clk,
    input  wire logic             rstn,
    input  wire logic [WIDTH-1:0] wrData,
    input  wire logic             wrValid,
    output logic                  wrReady,
    output logic [WIDTH-1:0]      rdData,
    output logic                  rdValid,
    input  wire logic             rdReady
);
    localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int unsigned CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
    localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

    typedef struct packed {
        logic [AW-1:0] wrPtr;
        logic [AW-1:0] rdPtr;
        logic [CW-1:0] count;
        logic          wrReady;
        logic          rdValid;
    } adcf_fifo_state_t;

    adcf_fifo_state_t r;
    adcf_fifo_state_t s;
    logic [WIDTH-1:0] mem [DEPTH];
    logic             push;
    logic             pop;

    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        bump = (p == LAST_PTR) ? '0 : p + AW'(1);
    endfunction

    assign push    = wrValid & r.wrReady;
    assign pop     = rdReady & r.rdValid;
    assign wrReady = r.wrReady;
    assign rdValid = r.rdValid;
    assign rdData  = mem[r.rdPtr];

    always_comb begin
        s = r;
        if (push) begin
            s.wrPtr = bump(r.wrPtr);
        end
        if (pop) begin
            s.rdPtr = bump(r.rdPtr);
        end
        case ({push, pop})
            2'b10:   s.count = r.count + CW'(1);
            2'b01:   s.count = r.count - CW'(1);
            default: s.count = r.count;
        endcase
        s.wrReady = (s.count != FULL_CNT);
        s.rdValid = (s.count != '0);
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            r <= '{wrPtr: '0, rdPtr: '0, count: '0,
                   wrReady: 1'b1, rdValid: 1'b0};
        end else begin
            r <= s;
        end
    end

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[r.wrPtr] <= wrData;
        end
    end

endmodule // adcf_fifo

// What this block does
// - retrack on each first fall, hold on 4th fall
// - serial clock gated off while select high
// - select fall gives first falling edge if clock low
// - clock high at select fall: wait first fall
// - capture input on first eight rises per conversion
// - received channel code applies to next conversion
// - simultaneous falls: next rise is first capture
// - channel code in bits 5..3, rest ignored
// - code 0 first input, binary order to eighth
// - result is unsigned straight binary, 12 bits
// - down while select high; while low, powered from first to 16th fall
// - power down from 16th fall to next first
// - 16 cycles per conversion, back to back
// - output driven only while select low
// - track three cycles, then shift result MSB first
module adcf_frame_ctrl #(
    parameter int unsigned FIFO_DEPTH = adcf_pkg::FIFO_DEPTH
) (
    input  wire logic          core_clk,
    input  wire logic          rstn,
    input  wire logic          csN,
    input  wire logic          sclk,
    input  wire logic          din,
    input  wire logic [11:0]   resData,
    input  wire logic          resValid,
    output logic               resReady,
    output logic               dout,
    output logic               doutOe,
    output adcf_pkg::adcf_mode_t mode,
    output logic [2:0]         chanSel,
    output logic [7:0]         ctrlWord,
    output logic               ctrlStrobe,
    output logic               sampleStrobe,
    output logic               underrun
);
    adcf_pkg::adcf_state_t  r;
    adcf_pkg::adcf_state_t  s;
    adcf_pkg::adcf_result_t head;
    logic                   popReq;
    logic                   csHigh;
    logic                   iclk;
    logic                   fallE;
    logic                   riseE;
    logic [4:0]             nFall;
    logic [4:0]             nRise;
    logic [7:0]             nWord;

    // one step of a 16-edge group; idle or full count restarts at one
    function automatic logic [4:0] stepCnt(input logic [4:0] c);
        if (c == adcf_pkg::CNT_IDLE || c == adcf_pkg::CNT_LAST) begin
            stepCnt = adcf_pkg::CNT_FIRST;
        end else begin
            stepCnt = c + 5'h01;
        end
    endfunction

    // mode after a fall event with new count n; code 2'h2 is never
    // reached along the gray path, so it falls back to power-down
    function automatic adcf_pkg::adcf_mode_t nextMode(
        input adcf_pkg::adcf_mode_t m,
        input logic [4:0]           n
    );
        nextMode = m;
        unique case (m)
            adcf_pkg::MODE_DOWN: begin
                if (n == adcf_pkg::CNT_FIRST) begin
                    nextMode = adcf_pkg::MODE_TRACK;
                end
            end
            adcf_pkg::MODE_TRACK: begin
                if (n == adcf_pkg::CNT_HOLD) begin
                    nextMode = adcf_pkg::MODE_HOLD;
                end
            end
            adcf_pkg::MODE_HOLD: begin
                if (n == adcf_pkg::CNT_LAST) begin
                    nextMode = adcf_pkg::MODE_DOWN;
                end else if (n == adcf_pkg::CNT_FIRST) begin
                    nextMode = adcf_pkg::MODE_TRACK;
                end
            end
            default: begin
                nextMode = adcf_pkg::MODE_DOWN;
            end
        endcase
    endfunction

    adcf_fifo #(
        .WIDTH (adcf_pkg::RES_BITS),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .core_clk (core_clk),
        .rstn     (rstn),
        .wrData   (resData),
        .wrValid  (resValid),
        .wrReady  (resReady),
        .rdData   (head.data),
        .rdValid  (head.valid),
        .rdReady  (popReq)
    );

    // internal clock is held high while select is high, so no edges
    // reach the counters a low clock at select fall turns the
    // select fall into the first falling edge a high one waits
    // for the clock's own fall
    assign csHigh = r.csSync[1];
    assign iclk   = r.sclkSync[1] | csHigh;
    assign fallE  = r.iclkPrev & ~iclk;
    assign riseE  = ~r.iclkPrev & iclk & ~csHigh;
    assign nFall  = stepCnt(r.fallCnt);
    assign nRise  = stepCnt(r.riseCnt);
    assign nWord  = {r.shiftIn[6:0], r.dinSync[1]};
    assign popReq = fallE & (nFall == adcf_pkg::CNT_FIRST);

    always_comb begin
        s              = r;
        s.csSync       = {r.csSync[0], csN};
        s.sclkSync     = {r.sclkSync[0], sclk};
        s.dinSync      = {r.dinSync[0], din};
        s.iclkPrev     = iclk;
        s.ctrlStrobe   = 1'b0;
        s.sampleStrobe = 1'b0;
        s.underrun     = 1'b0;
        s.doutOe       = ~csHigh;
        if (csHigh) begin
            s.fallCnt  = adcf_pkg::CNT_IDLE;
            s.riseCnt  = adcf_pkg::CNT_IDLE;
            s.mode     = adcf_pkg::MODE_DOWN;
            s.shiftOut = '0;
        end else begin
            if (fallE) begin
                s.fallCnt = nFall;
                s.mode    = nextMode(r.mode, nFall);
                if (nFall == adcf_pkg::CNT_FIRST) begin
                    // new conversion starts, back to back in a frame
                    s.chan = r.pendChan;
                    if (head.valid) begin
                        s.shiftOut = {adcf_pkg::LEAD_ZEROS,
                                      head.data};
                    end else begin
                        s.shiftOut = '0;
                        s.underrun = 1'b1;
                    end
                end else begin
                    s.shiftOut = {r.shiftOut[14:0], 1'b0};
                    if (nFall == adcf_pkg::CNT_HOLD) begin
                        s.sampleStrobe = 1'b1;
                    end
                end
            end
            if (riseE) begin
                // counting starts at the first rise after the frame's
                // first internal fall, also when both fall together
                s.riseCnt = nRise;
                if (nRise <= adcf_pkg::CNT_CTRL) begin
                    s.shiftIn = nWord;
                end
                if (nRise == adcf_pkg::CNT_CTRL) begin
                    s.ctrlWord   = nWord;
                    s.ctrlStrobe = 1'b1;
                    s.pendChan   = nWord[adcf_pkg::CHAN_MSB:
                                         adcf_pkg::CHAN_LSB];
                end
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            r <= '{csSync:       adcf_pkg::SYNC_CS_RST,
                   sclkSync:     adcf_pkg::SYNC_LO_RST,
                   dinSync:      adcf_pkg::SYNC_LO_RST,
                   iclkPrev:     1'b1,
                   fallCnt:      adcf_pkg::CNT_IDLE,
                   riseCnt:      adcf_pkg::CNT_IDLE,
                   shiftIn:      adcf_pkg::CTRL_RESET,
                   ctrlWord:     adcf_pkg::CTRL_RESET,
                   pendChan:     adcf_pkg::CHAN_RESET,
                   chan:         adcf_pkg::CHAN_RESET,
                   shiftOut:     '0,
                   mode:         adcf_pkg::MODE_DOWN,
                   doutOe:       1'b0,
                   ctrlStrobe:   1'b0,
                   sampleStrobe: 1'b0,
                   underrun:     1'b0};
        end else begin
            r <= s;
        end
    end

    assign dout         = r.shiftOut[adcf_pkg::OUT_BITS-1];
    assign doutOe       = r.doutOe;
    assign mode         = r.mode;
    assign chanSel      = r.chan;
    assign ctrlWord     = r.ctrlWord;
    assign ctrlStrobe   = r.ctrlStrobe;
    assign sampleStrobe = r.sampleStrobe;
    assign underrun     = r.underrun;

endmodule // adcf_frame_ctrl

// ---- verification/adcf_frame_ctrl_props.sv ----
// assertions on the ports of the serial frame controller
// assumes one core clock domain with an active-low reset
module adcf_frame_ctrl_props #(
    parameter int unsigned FIFO_DEPTH = adcf_pkg::FIFO_DEPTH
) (
    input wire logic                 core_clk,
    input wire logic                 rstn,
    input wire logic                 csN,
    input wire logic                 sclk,
    input wire logic                 din,
    input wire logic [11:0]          resData,
    input wire logic                 resValid,
    input wire logic                 resReady,
    input wire logic                 dout,
    input wire logic                 doutOe,
    input wire adcf_pkg::adcf_mode_t mode,
    input wire logic [2:0]           chanSel,
    input wire logic [7:0]           ctrlWord,
    input wire logic                 ctrlStrobe,
    input wire logic                 sampleStrobe,
    input wire logic                 underrun
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    sequence sEnterTrack;
        mode == adcf_pkg::MODE_TRACK && $past(mode) == adcf_pkg::MODE_DOWN;
    endsequence
    sequence sEnterHold;
        mode == adcf_pkg::MODE_HOLD && $past(mode) != adcf_pkg::MODE_HOLD;
    endsequence
    AST_IDLE_DESELECTED: assert property (
        csN [*5] |-> !doutOe && !dout && mode == adcf_pkg::MODE_DOWN
            && !ctrlStrobe && !sampleStrobe)
        else $error("outputs active while deselected");
    AST_DRIVE_SELECTED: assert property (
        !csN [*5] |-> doutOe) else $error("output undriven");
    AST_HOLD_AFTER_TRACK: assert property (
        sEnterHold |-> $past(mode) == adcf_pkg::MODE_TRACK && sampleStrobe)
        else $error("hold entered out of order");
    AST_TRACK_AFTER_DOWN: assert property (
        mode == adcf_pkg::MODE_TRACK && $past(mode) != adcf_pkg::MODE_TRACK
            |-> sEnterTrack) else $error("track entered out of order");
    AST_CHAN_FROM_CTRL: assert property (
        sEnterTrack |-> chanSel == ctrlWord[5:3])
        else $error("channel differs from control word");
    AST_CHAN_AT_START: assert property (
        $changed(chanSel) |-> sEnterTrack) else $error("channel moved");
    AST_SAMPLE_PULSE: assert property (
        sampleStrobe |=> !sampleStrobe && mode == adcf_pkg::MODE_HOLD)
        else $error("sample strobe malformed");
    AST_CTRL_PULSE: assert property (
        ctrlStrobe |=> !ctrlStrobe) else $error("control strobe too long");
    AST_CTRL_WITH_STROBE: assert property (
        $changed(ctrlWord) |-> ctrlStrobe) else $error("control word moved");
endmodule // adcf_frame_ctrl_props

// ---- verification/adcf_host_model.sv ----
// host on the serial link: frames conversions over csN, sclk and din
// assumes core_clk at 100 MHz; sclk period is 16 core cycles
module adcf_host_model (
    input  wire logic core_clk,
    output logic      csN,
    output logic      sclk,
    output logic      din,
    input  wire logic dout
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HALF = 8;
    initial begin
        csN = 1'b1;
        sclk = 1'b0;
        din = 1'b0;
    end
    task automatic select(input logic together);
        csN <= 1'b0;
        if (together) sclk <= 1'b0;
        repeat (HALF) @(posedge core_clk);
    endtask
    // only whole 16-cycle conversions are framed
    task automatic deselect();
        csN <= 1'b1;
        din <= ~din;
        repeat (2 * HALF) @(posedge core_clk);
    endtask
    task automatic convert(input logic [7:0] ctrl, output logic [15:0] word);
        for (int k = 0; k < 16; k++) begin
            sclk <= 1'b0;
            din  <= (k < 8) ? ctrl[7 - k] : ~din;
            repeat (HALF) @(posedge core_clk);
            word[15 - k] = dout;
            sclk <= 1'b1;
            repeat (HALF) @(posedge core_clk);
        end
    endtask
endmodule // adcf_host_model

// ---- verification/test_adcf_frame_ctrl.sv ----
// self-checking bench of the serial frame controller and its buffer
// assumes the host model on the link and the checker bound below
module test_adcf_frame_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    logic                 core_clk, rstn, csN, sclk, din, dout, doutOe;
    logic                 resValid, resReady, ctrlStrobe, sampleStrobe;
    logic                 underrun;
    logic                 sawUnder = 1'b0;
    logic [11:0]          resData;
    logic [2:0]           chanSel;
    logic [2:0]           prevChan = 3'h0;
    logic [7:0]           ctrlWord;
    adcf_pkg::adcf_mode_t mode;
    logic [11:0]          expQ[$];
    int                   errorCnt, compares;

    adcf_frame_ctrl adcf_frame_ctrl_inst (.core_clk(core_clk), .rstn(rstn),
        .csN(csN), .sclk(sclk), .din(din), .resData(resData),
        .resValid(resValid), .resReady(resReady), .dout(dout),
        .doutOe(doutOe), .mode(mode), .chanSel(chanSel),
        .ctrlWord(ctrlWord), .ctrlStrobe(ctrlStrobe),
        .sampleStrobe(sampleStrobe), .underrun(underrun));
    adcf_host_model adcf_host_model_inst (.core_clk(core_clk), .csN(csN),
        .sclk(sclk), .din(din), .dout(dout));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) if (underrun === 1'b1) sawUnder <= 1'b1;

    task automatic check(input string what, input logic [15:0] exp,
                         input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            errorCnt++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic end_of_test();
        $display("compares %0d mismatches %0d", compares, errorCnt);
        if (errorCnt == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic push(input logic [11:0] w);
        int n;
        n = 0;
        resData  <= w;
        resValid <= 1'b1;
        #1;
        while (resReady !== 1'b1 && n < 50) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        if (n == 50) begin
            errorCnt++;
            end_of_test();
        end
        @(posedge core_clk);
        expQ.push_back(w);
    endtask
    // n whole conversions; each control word names the next channel
    task automatic frame(input int n, input logic together);
        logic [15:0] word;
        logic [2:0]  code;
        logic [7:0]  ctrl;
        logic [15:0] expWord;
        adcf_host_model_inst.select(together);
        for (int i = 0; i < n; i++) begin
            code = 3'(7 - i);
            ctrl = {2'h2, code, 3'h5};
            adcf_host_model_inst.convert(ctrl, word);
            expWord = 16'h0000;
            if (expQ.size() > 0) expWord = {4'h0, expQ.pop_front()};
            check("dout", expWord, word);
            check("chanSel", {13'h0, prevChan}, {13'h0, chanSel});
            check("ctrlWord", {8'h0, ctrl}, {8'h0, ctrlWord});
            check("mode", 16'h0, {14'h0, mode});
            prevChan = code;
        end
        adcf_host_model_inst.deselect();
        check("released", 16'h0, {14'h0, doutOe, dout});
        $display("test frame of %0d done", n);
    endtask

    initial begin
        repeat (100000) @(posedge core_clk);
        errorCnt++;
        end_of_test();
    end
    initial begin
        rstn = 1'b0;
        resData = 12'h000;
        resValid = 1'b0;
        repeat (8) @(posedge core_clk);
        rstn <= 1'b1;
        repeat (4) @(posedge core_clk);
        check("reset", 16'h0001, {11'h0, chanSel, 1'b0, resReady});
        for (int i = 0; i < 8; i++) push(12'h5A3 + 12'(i) * 12'h137);
        resValid <= 1'b0;
        repeat (2) @(posedge core_clk);
        resData  <= 12'hFFF;
        resValid <= 1'b1;
        repeat (4) @(posedge core_clk);
        check("resReady", 16'h0, {15'h0, resReady});
        resValid <= 1'b0;
        $display("test fill done");
        frame(9, 1'b0);
        check("underrun", 16'h0001, {15'h0, sawUnder});
        for (int i = 0; i < 2; i++) push(12'h0F0 + 12'(i));
        resValid <= 1'b0;
        frame(1, 1'b0);
        frame(1, 1'b1);
        end_of_test();
    end
endmodule // test_adcf_frame_ctrl

bind adcf_frame_ctrl adcf_frame_ctrl_props #(.FIFO_DEPTH(FIFO_DEPTH))
    adcf_frame_ctrl_props_inst (.core_clk(core_clk), .rstn(rstn),
    .csN(csN), .sclk(sclk), .din(din), .resData(resData),
    .resValid(resValid), .resReady(resReady), .dout(dout),
    .doutOe(doutOe), .mode(mode), .chanSel(chanSel), .ctrlWord(ctrlWord),
    .ctrlStrobe(ctrlStrobe), .sampleStrobe(sampleStrobe),
    .underrun(underrun));
